// ==== test/ppm_mem_model.sv ====
// partner model: external memory answering on the ready pin
`timescale 1ns/1ps

module ppm_mem_model (
  input wire logic clk,
  input wire logic [2:0] cs_pad,
  input wire logic pullup_en,
  input wire logic [3:0] hold,
  output logic ready_pad
);
  logic driving = 1'b0;
  logic level = 1'b1;
  logic last = 1'b1;
  logic [3:0] cnt = 4'h0;
  // released line: pulled high, else shows the inverse of its last value
  assign ready_pad = driving ? level : (pullup_en ? 1'b1 : ~last);
  always @(negedge clk) begin
    if (cs_pad != 3'h7 && !driving) begin
      driving <= 1'b1;
      level <= 1'b0;
      cnt <= hold;
    end else if (cs_pad == 3'h7 && driving) begin
      driving <= 1'b0;
      last <= level;
    end else if (driving && cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
      if (cnt == 4'h1) begin
        level <= 1'b1;
      end
    end
  end
endmodule

// ==== test/ppm_pin_mux_tb_top.sv ====
// self-checking testbench for the parallel-port pin function mux
`timescale 1ns/1ps

module ppm_pin_mux_tb_top;
  import ppm_pkg::*;
  logic clk, rdy, pu_en, wait_o, done, mode;
  logic rst_n = 1'b0;
  logic strap = 1'b1;
  logic pud = 1'b0;
  logic start = 1'b0;
  logic [3:0] dir = 4'h0;
  logic [3:0] gout = 4'h0;
  logic [3:0] hold = 4'h1;
  logic [2:0] cs_n = 3'h7;
  logic [2:0] pad_drv = 3'h7;
  wire [3:0] oe, out, gin;
  logic [2:0] cs_pad;
  int mismatches = 0;
  int compares = 0;
  int cycles = 0;
  int wcnt = 0;
  int seed = 8108;
  logic [7:0] expq[$];

  ppm_pin_mux ppm_pin_mux_inst (.clk(clk), .rst_n(rst_n), .function_strap_pin(strap),
    .par_io_bit23_in(oe[0] ? out[0] : rdy), .par_io_bit23_out(out[0]), .par_io_bit23_oe(oe[0]),
    .par_io_bit24_in(cs_pad[0]), .par_io_bit24_out(out[1]), .par_io_bit24_oe(oe[1]),
    .par_io_bit25_in(cs_pad[1]), .par_io_bit25_out(out[2]), .par_io_bit25_oe(oe[2]),
    .par_io_bit26_in(cs_pad[2]), .par_io_bit26_out(out[3]), .par_io_bit26_oe(oe[3]),
    .ready_pullup_en(pu_en), .ext_bus_ctrl_pullup_dis(pud), .gpio_dir(dir), .gpio_out(gout),
    .gpio_in(gin), .mem_cs_n(cs_n), .mem_access_start(start), .mem_wait(wait_o),
    .mem_access_done(done), .emif_mode(mode));
  ppm_mem_model ppm_mem_model_inst (.clk(clk), .cs_pad(cs_pad), .pullup_en(pu_en),
    .hold(hold), .ready_pad(rdy));
  assign cs_pad = (oe[3:1] & out[3:1]) | (~oe[3:1] & pad_drv);

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic do_reset(logic s);
    rst_n = 1'b0;
    strap = s;
    repeat (16) @(negedge clk);
    check("oe_in_reset", oe, 8'h0);
    check("mode_in_reset", mode, 8'h0);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
  endtask

  // expected wait count: ready low for h cycles, one of them hidden by sync and start
  task automatic access(int k, logic [3:0] h, logic em);
    hold = h;
    cs_n = ~(3'h1 << k);
    @(negedge clk);
    if (em) check("cs_pads", out[3:1], cs_n);
    repeat (2) @(negedge clk);
    expq.push_back(em ? 8'(h - 4'h1) : 8'h0);
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    for (int i = 0; i < 20 && expq.size() > 0; i++) @(negedge clk);
    cs_n = 3'h7;
    @(negedge clk);
  endtask

  always @(negedge clk) begin
    if (done === 1'b1) begin
      check("wait_cycles", 8'(wcnt), expq.pop_front());
      wcnt = 0;
    end else if (wait_o === 1'b1) begin
      wcnt++;
    end
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      mismatches++;
      end_of_test();
    end
  end

  initial begin
    do_reset(1'b1);
    check("emif_mode", mode, 8'h1);
    check("pad_oe", oe, 8'he);
    check("pad_out", out[3:1], 8'h7);
    check("pullup_en", pu_en, 8'h1);
    strap = 1'b0;
    repeat (4) @(negedge clk);
    check("mode_held", mode, 8'h1);
    check("ready_pin_oe", oe[0], 8'h0);
    access(0, 4'h1, 1'b1);
    for (int k = 0; k < 3; k++) access(k, 4'(2 + $unsigned($random(seed)) % 5), 1'b1);
    pud = 1'b1;
    repeat (2) @(negedge clk);
    check("pullup_off", pu_en, 8'h0);
    pud = 1'b0;
    $display("emif test done");
    do_reset(1'b0);
    check("gpio_mode", mode, 8'h0);
    check("gpio_oe", oe, 8'h0);
    access(1, 4'h4, 1'b0);
    pad_drv = 3'($random(seed));
    repeat (4) @(negedge clk);
    check("gpio_in", gin[3:1], pad_drv);
    dir = 4'($random(seed));
    gout = 4'($random(seed));
    repeat (2) @(negedge clk);
    check("gpio_oe_dir", oe, dir);
    check("gpio_out", out & dir, gout & dir);
    $display("gpio test done");
    end_of_test();
  end
endmodule

// ==== verilog/ppm_pin_mux.sv ====
// parallel-port pin function mux: gpio or memory-interface chip selects and ready
`timescale 1ns/1ps
`include "ppm_regs.svh"

// Operation
// R1: strap low during reset selects gpio; strap high selects memory-interface pins.
// R2: chosen pin function takes effect when reset is released.
// R3: pins in gpio function come up as inputs after reset; code loads gpio_dir into dir_q on the release edge instead.
// R4: chip selects float during reset, then drive logic 1.
// R5: three chip-select outputs, one per memory space, each on its own pin.
// R6: external device drives ready high when done, low while not ready.
// R7: ready sampled low extends the access one cycle and samples again.
// R8: internal pull-up on ready, software can disable it via bus control register.
// R9: ready shares a pin with gpio, chosen by strap high during reset.
// R10: latched pin function stays fixed until the next reset release.
module ppm_pin_mux
  import ppm_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic function_strap_pin,
  input wire logic par_io_bit23_in,
  output logic par_io_bit23_out,
  output logic par_io_bit23_oe,
  input wire logic par_io_bit24_in,
  output logic par_io_bit24_out,
  output logic par_io_bit24_oe,
  input wire logic par_io_bit25_in,
  output logic par_io_bit25_out,
  output logic par_io_bit25_oe,
  input wire logic par_io_bit26_in,
  output logic par_io_bit26_out,
  output logic par_io_bit26_oe,
  output logic ready_pullup_en,
  input wire logic ext_bus_ctrl_pullup_dis,
  input wire logic [`PPM_NUM_PINS-1:0] gpio_dir,
  input wire logic [`PPM_NUM_PINS-1:0] gpio_out,
  output logic [`PPM_NUM_PINS-1:0] gpio_in,
  input wire logic [`PPM_NUM_CS-1:0] mem_cs_n,
  input wire logic mem_access_start,
  output logic mem_wait,
  output logic mem_access_done,
  output logic emif_mode
);

  // ****************************************
  // pin input synchronisers
  // ****************************************
  logic [`PPM_NUM_PINS:0] pins_raw;
  logic [`PPM_NUM_PINS:0] pins_sync;
  logic strap_sync;
  logic ready_sync;

  assign pins_raw = {function_strap_pin, par_io_bit26_in, par_io_bit25_in,
                     par_io_bit24_in, par_io_bit23_in};

  ppm_sync #(
    .WIDTH(`PPM_NUM_PINS + 1)
  ) u_sync (
    .clk(clk),
    .async_in(pins_raw),
    .sync_out(pins_sync)
  );

  assign strap_sync = pins_sync[`PPM_NUM_PINS];
  assign ready_sync = pins_sync[`PPM_PIN_READY];

  // ****************************************
  // strap capture
  // ****************************************
  // the strap is caught on the first edge after release; reset itself can
  // only load constants, so pins stay released (oe low) until then
  ppm_func_t mode;
  logic latched;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      latched <= 1'b0;
    end else begin
      latched <= 1'b1; // R2
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode <= PPM_FN_GPIO;
    end else if (!latched) begin
      mode <= ppm_func_t'(strap_sync); // R1 R9
    end
  end
  // later strap activity is ignored until the next reset R10

  assign emif_mode = latched && (mode == PPM_FN_EMIF);

  // ****************************************
  // gpio direction and data
  // ****************************************
  logic [`PPM_NUM_PINS-1:0] dir_q;
  logic [`PPM_NUM_PINS-1:0] out_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dir_q <= `PPM_DIR_RESET; // R3
      out_q <= `PPM_OUT_RESET;
    end else begin
      dir_q <= gpio_dir;
      out_q <= gpio_out;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gpio_in <= `PPM_OUT_RESET;
    end else begin
      gpio_in <= pins_sync[`PPM_NUM_PINS-1:0];
    end
  end

  // ****************************************
  // chip selects
  // ****************************************
  logic [`PPM_NUM_CS-1:0] cs_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_q <= `PPM_CS_IDLE; // R4
    end else if (!latched) begin
      cs_q <= `PPM_CS_IDLE; // R4
    end else begin
      cs_q <= mem_cs_n; // R5
    end
  end

  // ****************************************
  // pad drivers
  // ****************************************
  logic [`PPM_NUM_PINS-1:0] pad_oe;
  logic [`PPM_NUM_PINS-1:0] pad_out;

  always_comb begin
    pad_oe = `PPM_OE_OFF;
    pad_out = out_q;
    if (latched) begin
      if (mode == PPM_FN_EMIF) begin
        pad_oe = {{`PPM_NUM_CS{1'b1}}, 1'b0}; // R4 R9
        pad_out = {cs_q, 1'b0}; // R5
      end else begin
        pad_oe = dir_q; // R3
      end
    end
  end

  assign par_io_bit23_out = pad_out[0];
  assign par_io_bit23_oe = pad_oe[0];
  assign par_io_bit24_out = pad_out[1];
  assign par_io_bit24_oe = pad_oe[1];
  assign par_io_bit25_out = pad_out[2];
  assign par_io_bit25_oe = pad_oe[2];
  assign par_io_bit26_out = pad_out[3];
  assign par_io_bit26_oe = pad_oe[3];

  // ****************************************
  // ready pull-up
  // ****************************************
  // the pull-up keeps an unconnected ready high so accesses never stall
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ready_pullup_en <= 1'b0;
    end else begin
      ready_pullup_en <= emif_mode && !ext_bus_ctrl_pullup_dis; // R8
    end
  end

  // ****************************************
  // wait extension
  // ****************************************
  // in gpio function there is no ready pin, so accesses are never extended
  ppm_acc_t acc_state;
  logic ready_eff;

  assign ready_eff = emif_mode ? ready_sync : 1'b1; // R6 R9

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_state <= PPM_ACC_IDLE;
    end else begin
      unique case (acc_state)
        PPM_ACC_IDLE: begin
          if (mem_access_start) begin
            acc_state <= PPM_ACC_CHECK;
          end
        end
        PPM_ACC_CHECK: begin
          if (ready_eff) begin
            acc_state <= PPM_ACC_IDLE; // R7
          end
        end
      endcase
    end
  end

  assign mem_access_done = (acc_state == PPM_ACC_CHECK) && ready_eff; // R7
  assign mem_wait = (acc_state == PPM_ACC_CHECK) && !ready_eff; // R7

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_release;
    !latched ##1 latched;
  endsequence

  sequence s_not_ready;
    (acc_state == PPM_ACC_CHECK) && !ready_eff;
  endsequence

  property p_strap_select;
    s_release |-> (mode == ppm_func_t'($past(strap_sync)));
  endproperty
  a_strap_select: assert property (p_strap_select) // R1
    else $error("latched function differs from strap level");

  property p_float_until_release;
    !latched |-> (pad_oe == `PPM_OE_OFF);
  endproperty
  a_float_until_release: assert property (p_float_until_release) // R2
    else $error("pin driven before function applied");

  property p_gpio_input;
    s_release ##0 (mode == PPM_FN_GPIO) |-> (pad_oe == `PPM_OE_OFF);
  endproperty
  a_gpio_input: assert property (p_gpio_input) // R3
    else $error("gpio pin not an input after reset");

  property p_cs_idle;
    s_release ##0 (mode == PPM_FN_EMIF) |->
      (pad_oe[`PPM_NUM_PINS-1:1] == `PPM_CS_IDLE) &&
      (pad_out[`PPM_NUM_PINS-1:1] == `PPM_CS_IDLE);
  endproperty
  a_cs_idle: assert property (p_cs_idle) // R4
    else $error("chip selects not driven high after reset");

  property p_cs_follow;
    emif_mode ##1 emif_mode |-> (pad_out[`PPM_NUM_PINS-1:1] == $past(mem_cs_n));
  endproperty
  a_cs_follow: assert property (p_cs_follow) // R5
    else $error("chip-select pin does not follow request");

  property p_extend;
    s_not_ready |-> !mem_access_done ##1 (acc_state == PPM_ACC_CHECK);
  endproperty
  a_extend: assert property (p_extend) // R7
    else $error("access not extended while ready low");

  property p_complete;
    (acc_state == PPM_ACC_CHECK) && ready_eff |-> mem_access_done ##1 (acc_state == PPM_ACC_IDLE);
  endproperty
  a_complete: assert property (p_complete) // R7
    else $error("access not completed on ready high");

  property p_pullup;
    latched |=> (ready_pullup_en == (emif_mode && !$past(ext_bus_ctrl_pullup_dis)));
  endproperty
  a_pullup: assert property (p_pullup) // R8
    else $error("ready pull-up enable wrong");

  property p_ready_input;
    emif_mode |-> !par_io_bit23_oe;
  endproperty
  a_ready_input: assert property (p_ready_input) // R9
    else $error("ready pin driven in memory-interface function");

  property p_mode_hold;
    latched ##1 latched |-> $stable(mode);
  endproperty
  a_mode_hold: assert property (p_mode_hold) // R10
    else $error("pin function changed outside reset");

endmodule

// ==== verilog/ppm_pkg.sv ====
// types for the parallel-port pin function mux
package ppm_pkg;

  // gpio comes first so a low strap maps to it
  typedef enum logic {
    PPM_FN_GPIO,
    PPM_FN_EMIF
  } ppm_func_t;

  typedef enum logic {
    PPM_ACC_IDLE,
    PPM_ACC_CHECK
  } ppm_acc_t;

endpackage

// ==== verilog/ppm_regs.svh ====
// constants for the parallel-port pin function mux
`ifndef PPM_REGS_SVH
`define PPM_REGS_SVH

// ****************************************
// pin function encodings and reset values
// ****************************************
`define PPM_NUM_CS 3
`define PPM_NUM_PINS 4
`define PPM_CS_IDLE 3'h7
`define PPM_OE_OFF 4'h0
`define PPM_DIR_RESET 4'h0
`define PPM_OUT_RESET 4'h0
`define PPM_SYNC_STAGES 2
`define PPM_PIN_READY 0
`define PPM_PIN_CS0 1

`endif

// ==== verilog/ppm_sync.sv ====
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps

module ppm_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  // ****************************************
  // synchroniser stages
  // ****************************************
  // no reset: the chain keeps tracking the pin while reset is held, so the
  // strap level is already settled when reset is released
  logic [WIDTH-1:0] stage1;

  generate
    if (WIDTH < 1) begin : g_bad_width
      $error("ppm_sync: WIDTH must be at least 1");
    end
  endgenerate

  always_ff @(posedge clk) begin
    stage1 <= async_in;
  end

  always_ff @(posedge clk) begin
    sync_out <= stage1;
  end

endmodule
